// ==== include/sm_status_pkg.sv ====
package sm_status_pkg;

    // ----------------------------------------
    // widths
    // ----------------------------------------
    localparam int DATA_W = 32;
    localparam int NUM_LOC = 5;
    localparam int HOST_SYNC_W = DATA_W + 4;

    // ----------------------------------------
    // locality status register fields
    // ----------------------------------------
    localparam int STS_VALID_BIT = 7;
    localparam int STS_CMD_READY_BIT = 6;
    localparam int STS_GO_BIT = 5;
    localparam int STS_RESP_AVAIL_BIT = 4;
    localparam int STS_EXPECT_BIT = 3;
    localparam int STS_RETRY_BIT = 1;
    localparam int STS_LAUNCH_CLR_BIT = 25;
    localparam logic [31:0] STS_WR_MASK = 32'h0200_0062;

    // ----------------------------------------
    // locality access register fields
    // ----------------------------------------
    localparam int ACC_VALID_BIT = 7;
    localparam int ACC_LAUNCH_BIT = 0;

    // ----------------------------------------
    // reset values and timing
    // ----------------------------------------
    localparam logic LAUNCH_FLAG_RST = 1'b1;
    localparam logic [31:0] RD_DATA_RST = 32'h0000_0000;
    localparam logic [3:0] SETTLE_CYCLES = 4'h3;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_READY,
        ST_RECEIVE,
        ST_EXECUTE,
        ST_COMPLETE
    } cmd_state_t;

    // number of writable status fields set in a write word
    function automatic logic [5:0] field_count(input logic [31:0] d);
        logic [5:0] n;
        n = 6'h00;
        for (int i = 0; i < 32; i++)
        begin
            n = n + {5'h00, d[i] & STS_WR_MASK[i]};
        end
        return n;
    endfunction : field_count

endpackage : sm_status_pkg

// ==== design/link_sampler.sv ====
module link_sampler
    import sm_status_pkg::*;
(
    input wire logic clk,                   // core clock
    input wire logic rst_b,                 // async reset, active low
    input wire logic linkClk,               // host bus clock pin
    input wire logic [HOST_SYNC_W-1:0] din, // host pins
    output logic [HOST_SYNC_W-1:0] dout,    // synchronised host pins
    output logic linkRise                   // one-cycle pulse per link rise
);

    // ----------------------------------------
    // two-stage synchronisers
    // ----------------------------------------
    logic [HOST_SYNC_W-1:0] dMeta_reg;
    logic [HOST_SYNC_W-1:0] dSync_reg;
    logic [2:0] clkSh_reg;
    logic [2:0] clkSh_next;

    always_comb
    begin
        clkSh_next = {clkSh_reg[1:0], linkClk};
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dMeta_reg <= '0;
            dSync_reg <= '0;
            clkSh_reg <= 3'h0;
        end
        else
        begin
            dMeta_reg <= din;
            dSync_reg <= dMeta_reg;
            clkSh_reg <= clkSh_next;
        end
    end

    // edge found only from the second and third stages
    assign linkRise = clkSh_reg[1] & ~clkSh_reg[2];
    assign dout = dSync_reg;

endmodule : link_sampler

// ==== design/launch_flag_store.sv ====
module launch_flag_store
    import sm_status_pkg::*;
(
    input wire logic clk,          // core clock
    input wire logic rst_b,        // async reset, active low
    input wire logic nvValid,      // retained value is available
    input wire logic nvValue,      // retained flag value
    input wire logic launchRcv,    // launch command received, pulse
    input wire logic clearReq,     // software clear request, pulse
    output logic flag,             // current launch-absent flag
    output logic regValid,         // flag holds its true value
    output logic nvWrEn,           // write retained copy, pulse
    output logic nvWrData,         // value to retain
    output logic rootUpdateGo      // root register may update, pulse
);

    logic flag_reg;
    logic flag_next;
    logic loaded_reg;
    logic loaded_next;
    logic pend_reg;
    logic pend_next;
    logic wr_reg;
    logic wr_next;
    logic go_reg;
    logic go_next;

    // ----------------------------------------
    // flag update
    // ----------------------------------------
    always_comb
    begin
        flag_next = flag_reg;
        loaded_next = loaded_reg;
        pend_next = pend_reg;
        wr_next = 1'b0;
        go_next = 1'b0;
        if (!loaded_reg)
        begin
            if (nvValid)
            begin
                flag_next = nvValue;
                loaded_next = 1'b1;
            end
        end
        else if (launchRcv)
        begin
            // launch beats a clear in the same cycle
            flag_next = 1'b0;
            pend_next = 1'b1;
            wr_next = flag_reg;
        end
        else
        begin
            if (clearReq)
            begin
                flag_next = 1'b1;
                wr_next = ~flag_reg;
            end
            if (pend_reg && !flag_reg)
            begin
                go_next = 1'b1;
                pend_next = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            flag_reg <= LAUNCH_FLAG_RST;
            loaded_reg <= 1'b0;
            pend_reg <= 1'b0;
            wr_reg <= 1'b0;
            go_reg <= 1'b0;
        end
        else
        begin
            flag_reg <= flag_next;
            loaded_reg <= loaded_next;
            pend_reg <= pend_next;
            wr_reg <= wr_next;
            go_reg <= go_next;
        end
    end

    assign flag = flag_reg & loaded_reg;
    assign regValid = loaded_reg;
    assign nvWrEn = wr_reg;
    assign nvWrData = flag_reg;
    assign rootUpdateGo = go_reg;

endmodule : launch_flag_store

// ==== design/secure_module_status_regs.sv ====
module secure_module_status_regs
    import sm_status_pkg::*;
(
    input wire logic clk,                 // core clock, 250 MHz
    input wire logic rst_b,               // async reset, active low
    input wire logic linkClk,             // host bus clock pin
    input wire logic hostStsWr,           // status write strobe pin
    input wire logic hostStsRd,           // status read strobe pin
    input wire logic hostAccRd,           // access read strobe pin
    input wire logic hostFifoWr,          // command byte write pin
    input wire logic [31:0] hostWrData,   // host write data pins
    input wire logic execDone,            // engine finished, pulse
    input wire logic respAvailIn,         // response bytes remain
    input wire logic respLvlOk,           // respAvailIn is settled
    input wire logic expectIn,            // more command bytes expected
    input wire logic expectLvlOk,         // expectIn is settled
    input wire logic launchRcv,           // launch command seen, pulse
    input wire logic localityChg,         // active locality changed
    input wire logic fastReady,           // ack also readies device
    input wire logic nvValid,             // retained flag is loaded
    input wire logic nvValue,             // retained flag value
    output logic [31:0] rdData,           // read answer data
    output logic rdDone,                  // read answer strobe
    output logic rdWait,                  // status read held in wait
    output logic execStart,               // start command, pulse
    output logic execAbort,               // abort command, pulse
    output logic releaseRes,              // free both queues, pulse
    output logic prepReady,               // prepare for command, pulse
    output logic [NUM_LOC-1:0] launchLoc, // flag seen by each locality
    output logic accessRegValid,          // access register valid
    output logic rootUpdateGo,            // root register update, pulse
    output logic nvWrEn,                  // retained write, pulse
    output logic nvWrData                 // retained write value
);

    // ----------------------------------------
    // host pin sampling
    // ----------------------------------------
    logic [HOST_SYNC_W-1:0] hostRaw;
    logic [HOST_SYNC_W-1:0] hostSync;
    logic linkRise;
    logic [31:0] wrData;
    logic takeStsWr;
    logic takeStsRd;
    logic takeAccRd;
    logic takeFifoWr;

    assign hostRaw = {hostStsWr, hostStsRd, hostAccRd, hostFifoWr,
                      hostWrData};

    link_sampler u_sampler (
        .clk(clk),
        .rst_b(rst_b),
        .linkClk(linkClk),
        .din(hostRaw),
        .dout(hostSync),
        .linkRise(linkRise)
    );

    assign wrData = hostSync[DATA_W-1:0];
    assign takeStsWr = linkRise & hostSync[DATA_W+3];
    assign takeStsRd = linkRise & hostSync[DATA_W+2];
    assign takeAccRd = linkRise & hostSync[DATA_W+1];
    assign takeFifoWr = linkRise & hostSync[DATA_W];

    // ----------------------------------------
    // status write decode
    // ----------------------------------------
    logic [5:0] setCount;
    logic wrOk;
    logic readyWr;
    logic goWr;
    logic clearWr;

    always_comb
    begin
        setCount = field_count(wrData);
        wrOk = takeStsWr && (setCount == 6'h01);
        // zero fields are simply not acted upon
        readyWr = wrOk && wrData[STS_CMD_READY_BIT];
        goWr = wrOk && wrData[STS_GO_BIT];
        clearWr = wrOk && wrData[STS_LAUNCH_CLR_BIT];
    end

    // ----------------------------------------
    // launch flag
    // ----------------------------------------
    logic launchFlag;

    launch_flag_store u_flag (
        .clk(clk),
        .rst_b(rst_b),
        .nvValid(nvValid),
        .nvValue(nvValue),
        .launchRcv(launchRcv),
        .clearReq(clearWr),
        .flag(launchFlag),
        .regValid(accessRegValid),
        .nvWrEn(nvWrEn),
        .nvWrData(nvWrData),
        .rootUpdateGo(rootUpdateGo)
    );

    // one flag fanned out to every locality
    genvar gl;
    generate
        for (gl = 0; gl < NUM_LOC; gl++)
        begin : g_loc
            assign launchLoc[gl] = launchFlag;
        end
    endgenerate

    // ----------------------------------------
    // command state machine
    // ----------------------------------------
    cmd_state_t state_reg;
    cmd_state_t state_next;
    logic start_reg;
    logic start_next;
    logic abort_reg;
    logic abort_next;
    logic rel_reg;
    logic rel_next;
    logic prep_reg;
    logic prep_next;

    always_comb
    begin
        state_next = state_reg;
        start_next = 1'b0;
        abort_next = 1'b0;
        rel_next = 1'b0;
        prep_next = 1'b0;
        if (localityChg)
        begin
            state_next = ST_IDLE;
            abort_next = (state_reg == ST_EXECUTE);
            rel_next = 1'b1;
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE:
                begin
                    if (readyWr)
                    begin
                        state_next = ST_READY;
                        prep_next = 1'b1;
                    end
                end
                ST_READY:
                begin
                    if (takeFifoWr)
                    begin
                        state_next = ST_RECEIVE;
                    end
                end
                ST_RECEIVE:
                begin
                    if (goWr)
                    begin
                        state_next = ST_EXECUTE;
                        start_next = 1'b1;
                    end
                    else if (readyWr)
                    begin
                        // partial command discarded, ready again
                        state_next = ST_READY;
                        prep_next = 1'b1;
                        rel_next = 1'b1;
                    end
                end
                ST_EXECUTE:
                begin
                    if (readyWr)
                    begin
                        state_next = ST_IDLE;
                        abort_next = 1'b1;
                        rel_next = 1'b1;
                    end
                    else if (execDone)
                    begin
                        state_next = ST_COMPLETE;
                    end
                end
                ST_COMPLETE:
                begin
                    if (readyWr)
                    begin
                        rel_next = 1'b1;
                        if (fastReady)
                        begin
                            state_next = ST_READY;
                            prep_next = 1'b1;
                        end
                        else
                        begin
                            state_next = ST_IDLE;
                        end
                    end
                end
                default:
                begin
                    state_next = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= ST_IDLE;
            start_reg <= 1'b0;
            abort_reg <= 1'b0;
            rel_reg <= 1'b0;
            prep_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            start_reg <= start_next;
            abort_reg <= abort_next;
            rel_reg <= rel_next;
            prep_reg <= prep_next;
        end
    end

    assign execStart = start_reg;
    assign execAbort = abort_reg;
    assign releaseRes = rel_reg;
    assign prepReady = prep_reg;

    // ----------------------------------------
    // status word
    // ----------------------------------------
    logic [31:0] stsWord;
    logic [31:0] accWord;
    logic dynOk;

    always_comb
    begin
        dynOk = 1'b1;
        if ((state_reg == ST_COMPLETE) && !respLvlOk)
        begin
            dynOk = 1'b0;
        end
        if ((state_reg == ST_RECEIVE) && !expectLvlOk)
        begin
            dynOk = 1'b0;
        end
        stsWord = 32'h0000_0000;
        stsWord[STS_CMD_READY_BIT] = (state_reg == ST_READY);
        stsWord[STS_RESP_AVAIL_BIT] = (state_reg == ST_COMPLETE)
                                      && respAvailIn && respLvlOk;
        stsWord[STS_EXPECT_BIT] = (state_reg == ST_RECEIVE)
                                  && expectIn && expectLvlOk;
        stsWord[STS_VALID_BIT] = dynOk;
        accWord = 32'h0000_0000;
        accWord[ACC_VALID_BIT] = accessRegValid;
        accWord[ACC_LAUNCH_BIT] = launchFlag;
    end

    // ----------------------------------------
    // read answer with wait states
    // ----------------------------------------
    logic [3:0] settle_reg;
    logic [3:0] settle_next;
    logic pend_reg;
    logic pend_next;
    logic [31:0] rdData_reg;
    logic [31:0] rdData_next;
    logic done_reg;
    logic done_next;

    always_comb
    begin
        settle_next = settle_reg;
        pend_next = pend_reg;
        rdData_next = rdData_reg;
        done_next = 1'b0;
        if (state_next != state_reg)
        begin
            settle_next = SETTLE_CYCLES;
        end
        else if (settle_reg != 4'h0)
        begin
            settle_next = settle_reg - 4'h1;
        end
        if (takeStsRd)
        begin
            pend_next = 1'b1;
        end
        if (pend_reg && (settle_reg == 4'h0))
        begin
            // fields stable: release the held access
            rdData_next = stsWord;
            done_next = 1'b1;
            pend_next = 1'b0;
        end
        else if (takeAccRd)
        begin
            rdData_next = accWord;
            done_next = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            settle_reg <= 4'h0;
            pend_reg <= 1'b0;
            rdData_reg <= RD_DATA_RST;
            done_reg <= 1'b0;
        end
        else
        begin
            settle_reg <= settle_next;
            pend_reg <= pend_next;
            rdData_reg <= rdData_next;
            done_reg <= done_next;
        end
    end

    assign rdData = rdData_reg;
    assign rdDone = done_reg;
    assign rdWait = pend_reg;

endmodule : secure_module_status_regs

// ==== dv/status_regs_assertions.sv ====
module status_regs_checker
    import sm_status_pkg::*;
(
    input wire logic clk, // core clock
    input wire logic rst_b, // async reset, active low
    input wire logic [31:0] hostWrData, // host write data
    input wire logic launchRcv, // launch command pulse
    input wire logic [31:0] rdData, // read answer data
    input wire logic rdDone, // read answer strobe
    input wire logic rdWait, // status read in wait
    input wire logic execStart, // start pulse
    input wire logic execAbort, // abort pulse
    input wire logic releaseRes, // release pulse
    input wire logic prepReady, // prepare pulse
    input wire logic [NUM_LOC-1:0] launchLoc, // flag per locality
    input wire logic accessRegValid, // access register valid
    input wire logic rootUpdateGo // root update pulse
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_loc_same: assert property (
        launchLoc == '0 || launchLoc == '1)
        else $error("localities disagree on launch flag");
    a_unloaded_zero: assert property (
        !accessRegValid |-> launchLoc == '0)
        else $error("launch flag high before load");
    a_launch_clears: assert property (
        launchRcv && accessRegValid |-> ##[1:2] launchLoc == '0)
        else $error("launch flag not cleared");
    a_root_after: assert property (
        rootUpdateGo |-> launchLoc == '0 && $past(launchLoc) == '0)
        else $error("root update with flag set");
    a_flag_holds: assert property (
        accessRegValid && $past(accessRegValid) && $rose(launchLoc[0])
        |-> hostWrData[STS_LAUNCH_CLR_BIT])
        else $error("launch flag set without clear write");
    a_wait_bound: assert property (
        $rose(rdWait) |-> ##[1:4] (rdDone && !rdWait))
        else $error("status read wait too long");
    a_resp_valid: assert property (
        rdDone && $past(rdWait) && rdData[STS_RESP_AVAIL_BIT]
        |-> rdData[STS_VALID_BIT])
        else $error("response bit without valid");
    a_abort_frees: assert property (
        execAbort |-> releaseRes)
        else $error("abort without release");
    a_start_single: assert property (
        execStart |=> !execStart)
        else $error("start pulse too long");
    a_prep_alone: assert property (
        prepReady |-> !execStart && !execAbort)
        else $error("prepare with start or abort");
endmodule : status_regs_checker

bind secure_module_status_regs status_regs_checker chkr (
    .clk(clk), .rst_b(rst_b), .hostWrData(hostWrData),
    .launchRcv(launchRcv), .rdData(rdData), .rdDone(rdDone),
    .rdWait(rdWait), .execStart(execStart), .execAbort(execAbort),
    .releaseRes(releaseRes), .prepReady(prepReady),
    .launchLoc(launchLoc), .accessRegValid(accessRegValid),
    .rootUpdateGo(rootUpdateGo));

// ==== dv/host_bus_model.sv ====
module host_bus_model
(
    input wire logic clk, // core clock
    input wire logic rdDone, // read answer strobe
    input wire logic [31:0] rdData, // read answer data
    output logic linkClk = 1'b0, // bus clock, still between frames
    output logic hostStsWr = 1'b0, // status write strobe
    output logic hostStsRd = 1'b0, // status read strobe
    output logic hostAccRd = 1'b0, // access read strobe
    output logic hostFifoWr = 1'b0, // command byte write
    output logic [31:0] hostWrData = 32'h0000_0000 // write data
);
    timeunit 1ns;
    timeprecision 100ps;

    // one frame: k 0 status write, 1 status read, 2 access read, 3 byte
    task automatic xfer(input int k, input logic [31:0] d,
                        output logic [31:0] q);
        q = 'x;
        @(posedge clk);
        #1;
        hostWrData = d;
        {hostFifoWr, hostAccRd, hostStsRd, hostStsWr} = 4'h1 << k;
        #24 linkClk = 1'b1;
        for (int n = 0; n < 12; n++)
        begin
            @(posedge clk);
            if (rdDone === 1'b1)
                q = rdData;
            if (n == 5)
                #1 linkClk = 1'b0;
        end
        #1;
        {hostFifoWr, hostAccRd, hostStsRd, hostStsWr} = 4'h0;
        // released lines must not keep the old value
        hostWrData = ~d;
        if ((k == 1 || k == 2) && q === 'x)
        begin
            testbench.fails++;
            testbench.close_out();
        end
    endtask : xfer
endmodule : host_bus_model

// ==== dv/testbench.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk, rst_b, execDone, respAvailIn, respLvlOk, expectIn;
    logic expectLvlOk, launchRcv, localityChg, fastReady, nvValid;
    logic nvValue, rdDone, rdWait, execStart, execAbort;
    logic nvStore = 1'b1;
    logic releaseRes, prepReady, accessRegValid, rootUpdateGo, nvWrEn;
    logic nvWrData, linkClk, hostStsWr, hostStsRd, hostAccRd, hostFifoWr;
    logic [31:0] rdData, hostWrData, q;
    logic [4:0] launchLoc;
    logic [5:0] pv;
    logic [3:0] pc [6] = '{default: 4'h0};
    logic [3:0] pb [6];
    int fails, checksDone;

    host_bus_model host (.clk(clk), .rdDone(rdDone), .rdData(rdData),
        .linkClk(linkClk), .hostStsWr(hostStsWr), .hostStsRd(hostStsRd),
        .hostAccRd(hostAccRd), .hostFifoWr(hostFifoWr),
        .hostWrData(hostWrData));

    secure_module_status_regs dut (.clk(clk), .rst_b(rst_b),
        .linkClk(linkClk), .hostStsWr(hostStsWr), .hostStsRd(hostStsRd),
        .hostAccRd(hostAccRd), .hostFifoWr(hostFifoWr),
        .hostWrData(hostWrData), .execDone(execDone),
        .respAvailIn(respAvailIn), .respLvlOk(respLvlOk),
        .expectIn(expectIn), .expectLvlOk(expectLvlOk),
        .launchRcv(launchRcv), .localityChg(localityChg),
        .fastReady(fastReady), .nvValid(nvValid), .nvValue(nvValue),
        .rdData(rdData), .rdDone(rdDone), .rdWait(rdWait),
        .execStart(execStart), .execAbort(execAbort),
        .releaseRes(releaseRes), .prepReady(prepReady),
        .launchLoc(launchLoc), .accessRegValid(accessRegValid),
        .rootUpdateGo(rootUpdateGo), .nvWrEn(nvWrEn),
        .nvWrData(nvWrData));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // pulse counters and retained flag storage
    assign pv = {rootUpdateGo, nvWrEn, prepReady, releaseRes, execAbort,
                 execStart};
    always @(posedge clk)
    begin
        for (int i = 0; i < 6; i++)
            if (pv[i] === 1'b1)
                pc[i] <= pc[i] + 4'h1;
        if (nvWrEn === 1'b1)
            nvStore <= nvWrData;
    end

    function automatic logic [31:0] pk();
        return {8'h00, pc[5] - pb[5], pc[4] - pb[4], pc[3] - pb[3],
                pc[2] - pb[2], pc[1] - pb[1], pc[0] - pb[0]};
    endfunction : pk

    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        checksDone++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic close_out();
        $display("checks %0d, mismatches %0d", checksDone, fails);
        if (fails == 0 && checksDone > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out

    task automatic waitc(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : waitc

    task automatic pulse(ref logic s);
        waitc(1);
        s = 1'b1;
        waitc(1);
        s = 1'b0;
    endtask : pulse

    task automatic wr(logic [31:0] d);
        host.xfer(0, d, q);
    endtask : wr

    task automatic rd(int k);
        host.xfer(k, 32'h0000_0000, q);
    endtask : rd

    task automatic do_reset(logic v);
        rst_b = 1'b0;
        nvValid = 1'b0;
        nvValue = v;
        waitc(16);
        rst_b = 1'b1;
        waitc(2);
        chk("unloaded", {26'h0, accessRegValid, launchLoc}, 32'h0);
        nvValid = 1'b1;
        waitc(4);
    endtask : do_reset

    task automatic t_launch();
        rd(1);
        chk("idle", q & 32'h0000_00c0, 32'h0000_0080);
        rd(2);
        chk("access", q & 32'h0000_0081, 32'h0000_0081);
        chk("copies", {27'h0, launchLoc}, 32'h0000_001f);
        pb = pc;
        pulse(launchRcv);
        waitc(4);
        chk("cleared", {27'h0, launchLoc}, 32'h0000_0000);
        chk("launch pulses", pk(), 32'h0011_0000);
        rd(2);
        chk("access", q & 32'h0000_0081, 32'h0000_0080);
    endtask : t_launch

    task automatic t_cmd(logic fast);
        fastReady = fast;
        pb = pc;
        wr(32'h0000_0000);
        wr(32'h0000_0040);
        chk("prepare", pk(), 32'h0000_1000);
        rd(1);
        chk("ready", q & 32'h0000_00c0, 32'h0000_00c0);
        host.xfer(3, 32'h0000_00a5, q);
        rd(1);
        chk("receive", q & 32'h0000_00c8, 32'h0000_0088);
        expectLvlOk = 1'b0;
        rd(1);
        chk("expect unsettled", q & 32'h0000_0088, 32'h0000_0000);
        expectLvlOk = 1'b1;
        wr(32'h0000_0060);
        wr(32'h0000_0020);
        chk("start", pk(), 32'h0000_1001);
        pulse(execDone);
        rd(1);
        chk("complete", q & 32'h0000_00d0, 32'h0000_0090);
        respLvlOk = 1'b0;
        rd(1);
        chk("unsettled", q & 32'h0000_0080, 32'h0000_0000);
        respLvlOk = 1'b1;
        wr(32'h0000_0040);
        chk("release", {28'h0, pc[2] - pb[2]}, 32'h0000_0001);
        rd(1);
        chk("after ack", q & 32'h0000_0040,
            fast ? 32'h0000_0040 : 32'h0000_0000);
        if (!fast)
        begin
            wr(32'h0000_0040);
            rd(1);
            chk("second", q & 32'h0000_0040, 32'h0000_0040);
        end
        pulse(localityChg);
        rd(1);
        chk("moved", q & 32'h0000_0040, 32'h0000_0000);
    endtask : t_cmd

    task automatic t_abort();
        pb = pc;
        wr(32'h0000_0040);
        host.xfer(3, 32'h0000_005a, q);
        wr(32'h0000_0020);
        wr(32'h0000_0040);
        chk("abort", pk(), 32'h0000_1111);
        rd(1);
        chk("aborted", q & 32'h0000_0040, 32'h0000_0000);
        wr(32'h0000_0040);
        host.xfer(3, 32'h0000_005a, q);
        wr(32'h0000_0020);
        pb = pc;
        pulse(localityChg);
        waitc(3);
        chk("loc abort", pk(), 32'h0000_0110);
    endtask : t_abort

    task automatic t_retain();
        do_reset(nvStore);
        rd(2);
        chk("retained", q & 32'h0000_0081, 32'h0000_0080);
        wr(32'h0200_0040);
        rd(2);
        chk("two fields", q & 32'h0000_0081, 32'h0000_0080);
        wr(32'h0200_0000);
        rd(2);
        chk("cleared", q & 32'h0000_0081, 32'h0000_0081);
    endtask : t_retain

    initial
    begin
        fails = 0;
        checksDone = 0;
        {execDone, launchRcv, localityChg, fastReady} = 4'h0;
        {respAvailIn, respLvlOk, expectIn, expectLvlOk} = 4'hf;
        do_reset(1'b1);
        t_launch();
        t_cmd(1'b0);
        t_cmd(1'b1);
        t_abort();
        t_retain();
        close_out();
    end
endmodule : testbench
